// [shared/chain_spi_pkg.sv]
// Shared constants and the checksum function for the daisy-chained switch serial link
package chain_spi_pkg;
  localparam int WORD_BITS = 8;
  localparam int CH_COUNT = 4;
  localparam int CNT_W = 3;
  // Command word field positions
  localparam int SW_MSB = 7;
  localparam int SW_LSB = 4;
  localparam int CK_ODD = 3;
  localparam int CK_EVEN = 2;
  localparam int CK_ALL = 1;
  localparam int CK_ALL_INV = 0;
  // Controller register byte offsets and field bit positions
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_TX0 = 8'h10;
  localparam logic [7:0] OFF_RX0 = 8'h20;
  localparam int CTRL_START = 0;
  localparam int CTRL_CNT_LSB = 8;
  localparam int CTRL_CNT_W = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  // Serial clock half period in hclk cycles: 4 -> 40 ns, a 12.5 MHz link
  localparam int HALF_PERIOD = 4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  function automatic logic [3:0] checksum(input logic [3:0] sw);
    // sw[3:0] = ch4..ch1
    checksum = {sw[0] ^ sw[2], sw[1] ^ sw[3], ^sw, ~(^sw)};
  endfunction
endpackage

// [shared/chain_spi_if.sv]
// Serial link between the chain controller and the switch shift path
`timescale 1ns/100ps
interface chain_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport controller (
    output sclk,
    output cs_n,
    output mosi,
    input miso
  );
  modport device (
    input sclk,
    input cs_n,
    input mosi,
    output miso,
    output miso_oe
  );
endinterface

// [logic/switch_shift_path.sv]
// Device end: 8-bit shift path of one quad switch in a daisy chain
//
// Function
// - Controller output feeds first device, last returns
// - Shared clock and select; outputs chain onward
// - Word shifted in reappears out next 8
// - First 8 clocks carry own diagnostic word
// - Diagnostics move one device per 8 clocks
// - New word replaces old; final word counts
// - Apply configuration on select rising edge
// - Farthest device word first, then raise select
// - Word is switch bits then checksum
// - No fault flags during kickback clamping
// - Bits 7:4 switches ch4..1, 3:0 checksum
// - Odd, even, all, inverted-all checksum bits
// - Mode 0; output floats while deselected
// - Bad checksum or count: hold switches, flag low
`timescale 1ns/100ps
module switch_shift_path (
  input wire logic hclk,
  input wire logic hresetn,
  chain_spi_if.device link,
  input wire logic [3:0] overload,
  input wire logic [3:0] clamping,
  output logic [3:0] switch_on_bits,
  output logic serial_error_flag_n,
  output logic global_alarm_pin_n,
  output logic [3:0] live_thermal_fault,
  output logic [3:0] sticky_thermal_fault
);
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] mosi_s;
    logic [3:0] ovl_s1;
    logic [3:0] ovl_s2;
    logic [3:0] clp_s1;
    logic [3:0] clp_s2;
    logic [7:0] shreg;
    logic so;
    logic [2:0] cnt;
    logic any_clk;
    logic [3:0] sw;
    logic err_n;
    logic [3:0] sticky;
  } state_t;

  state_t r, n;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low;
  logic [3:0] live;
  logic ok;

  always_comb begin
    n = r;
    n.sclk_s = {r.sclk_s[1:0], link.sclk};
    n.cs_s = {r.cs_s[1:0], link.cs_n};
    n.mosi_s = {r.mosi_s[1:0], link.mosi};
    n.ovl_s1 = overload;
    n.ovl_s2 = r.ovl_s1;
    n.clp_s1 = clamping;
    n.clp_s2 = r.clp_s1;
    // A change counts while stage two has the new level and stage three the old
    sclk_rise = r.sclk_s[1] & ~r.sclk_s[2];
    sclk_fall = ~r.sclk_s[1] & r.sclk_s[2];
    cs_fall = ~r.cs_s[1] & r.cs_s[2];
    cs_rise = r.cs_s[1] & ~r.cs_s[2];
    cs_low = ~r.cs_s[2];
    // Off or clamping channels report no fault
    live = r.ovl_s2 & r.sw & ~r.clp_s2;
    n.sticky = r.sticky | live;
    ok = (r.shreg[3:0] == chain_spi_pkg::checksum(r.shreg[7:4])) && r.cnt == 3'h0
      && r.any_clk;
    if (cs_fall) begin
      n.shreg = {live, r.sticky};
      n.so = live[3];
      n.cnt = 3'h0;
      n.any_clk = 1'b0;
    end else if (cs_low && sclk_rise) begin
      // Each bit pushes the oldest out: word reappears 8 clocks later
      // Data stage level with the clock stage: upstream moves just before the edge
      n.shreg = {r.shreg[6:0], r.mosi_s[1]};
      n.cnt = r.cnt + 3'h1;
      n.any_clk = 1'b1;
    end else if (cs_low && sclk_fall) begin
      n.so = r.shreg[7];
    end
    // Stray clocks while deselected fall through untouched
    if (cs_rise) begin
      n.err_n = ok;
      if (ok) begin
        n.sw = r.shreg[7:4];
        n.sticky = live; // Cleared only on a clean transaction
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.sclk_s <= 3'h0;
      r.cs_s <= 3'h7;
      r.err_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.miso = r.so;
  assign link.miso_oe = ~r.cs_s[2];
  assign switch_on_bits = r.sw;
  assign serial_error_flag_n = r.err_n;
  assign live_thermal_fault = live;
  assign sticky_thermal_fault = r.sticky;
  assign global_alarm_pin_n = ~(|live);
endmodule // switch_shift_path

// [logic/chain_controller.sv]
// Controller end: AHB-Lite slave that drives a chain of switch devices
`timescale 1ns/100ps
module chain_controller #(
  parameter int MAX_DEV = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  chain_spi_if.controller link
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL = 2'b11
  } phase_t;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    phase_t ph;
    logic [2:0] div;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [2:0] miso_s;
    logic [2:0] bit_idx;
    logic [2:0] dev_idx;
    logic [2:0] dev_cnt;
    logic [7:0] sh;
    logic [1:0] ist;
    logic [1:0] imask;
    logic [MAX_DEV-1:0][7:0] tx;
    logic [MAX_DEV-1:0][7:0] rx;
  } state_t;

  state_t r, n;
  logic tick;
  logic [31:0] rd;

  always_comb begin
    n = r;
    n.miso_s = {r.miso_s[1:0], link.miso};
    tick = r.div == 3'(chain_spi_pkg::HALF_PERIOD - 1);
    n.div = tick ? 3'h0 : r.div + 3'h1;
    // Register writes take effect in the data phase
    n.wr_pend = hsel && htrans[1] && hwrite;
    if (hsel && htrans[1]) n.wr_addr = haddr;
    if (r.wr_pend) begin
      if (r.wr_addr == chain_spi_pkg::OFF_CTRL && hwdata[chain_spi_pkg::CTRL_START]
          && r.ph == ST_IDLE) begin
        n.dev_cnt = hwdata[chain_spi_pkg::CTRL_CNT_LSB +: chain_spi_pkg::CTRL_CNT_W];
        n.ph = ST_LEAD;
        n.div = 3'h0;
      end
      if (r.wr_addr == chain_spi_pkg::OFF_IRQ_STAT) n.ist = r.ist & ~hwdata[1:0];
      if (r.wr_addr == chain_spi_pkg::OFF_IRQ_MASK) n.imask = hwdata[1:0];
      for (int i = 0; i < MAX_DEV; i++) begin
        if (r.wr_addr == chain_spi_pkg::OFF_TX0 + 8'(4 * i)) n.tx[i] = {hwdata[7:4],
            chain_spi_pkg::checksum(hwdata[7:4])};
      end
    end
    case (r.ph)
      ST_IDLE: begin
        n.cs_n = 1'b1;
        n.sclk = 1'b0;
      end
      ST_LEAD: if (tick) begin
        // Farthest device word goes first
        n.cs_n = 1'b0;
        n.dev_idx = r.dev_cnt - 3'h1;
        n.sh = r.tx[r.dev_cnt - 3'h1];
        n.mosi = r.tx[r.dev_cnt - 3'h1][7];
        n.bit_idx = 3'h0;
        n.ph = (r.dev_cnt == 3'h0) ? ST_TAIL : ST_SHIFT;
      end
      ST_SHIFT: if (tick) begin
        if (!r.sclk) begin
          n.sclk = 1'b1;
        end else begin
          // Sampled late: the far end answers only three cycles after a fall
          n.sclk = 1'b0;
          n.sh = {r.sh[6:0], r.miso_s[2]};
          n.bit_idx = r.bit_idx + 3'h1;
          if (r.bit_idx == 3'h7) begin
            // Word i is sent while device i's diagnostics arrive
            n.rx[r.dev_idx] = {r.sh[6:0], r.miso_s[2]};
            if (r.dev_idx == 3'h0) begin
              n.ph = ST_TAIL;
            end else begin
              n.dev_idx = r.dev_idx - 3'h1;
              n.sh = r.tx[r.dev_idx - 3'h1];
              n.mosi = r.tx[r.dev_idx - 3'h1][7];
            end
          end else begin
            n.mosi = r.sh[6];
          end
        end
      end
      ST_TAIL: if (tick) begin
        n.cs_n = 1'b1;
        n.ph = ST_IDLE;
        n.ist[chain_spi_pkg::IRQ_DONE] = 1'b1;
      end
      default: n.ph = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.cs_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    rd = chain_spi_pkg::RESET_WORD;
    if (r.wr_addr == chain_spi_pkg::OFF_STATUS) rd[0] = r.ph != ST_IDLE;
    if (r.wr_addr == chain_spi_pkg::OFF_IRQ_STAT) rd[1:0] = r.ist;
    if (r.wr_addr == chain_spi_pkg::OFF_IRQ_MASK) rd[1:0] = r.imask;
    for (int i = 0; i < MAX_DEV; i++) begin
      if (r.wr_addr == chain_spi_pkg::OFF_TX0 + 8'(4 * i)) rd[7:0] = r.tx[i];
      if (r.wr_addr == chain_spi_pkg::OFF_RX0 + 8'(4 * i)) rd[7:0] = r.rx[i];
    end
  end

  assign hrdata = rd;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(r.ist & r.imask);
  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.mosi;
endmodule // chain_controller

// [tb/chain_spi_asserts.sv]
// Timing checks on the link between controller and first device
`timescale 1ns/100ps
module chain_spi_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic sclk_q;
  logic [5:0] rises;
  // Rising clock edges within the current frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      rises <= 6'h00;
    end else begin
      sclk_q <= sclk;
      rises <= cs_n ? 6'h00 : rises + {5'h00, sclk & ~sclk_q};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  a_whole_words: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0 && rises != 6'h00)
    else $error("frame not a whole number of words");
  a_out_floats: assert property (cs_n [*6] |-> !miso_oe)
    else $error("data output driven while deselected");
  a_out_drives: assert property ($fell(cs_n) |-> ##[1:6] miso_oe)
    else $error("data output not driven in frame");
  a_in_settled: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("data input moved at sampling edge");
  a_lead_in: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("clock rose too soon after select");
  a_high_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("clock high phase length wrong");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("clock low phase too short");
endmodule // chain_spi_asserts

// [tb/daisy_chain_switch_spi_test.sv]
// Two-device chain behind the bus controller
`timescale 1ns/100ps
module daisy_chain_switch_spi_test;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic hreadyout, hresp, irq;
  logic [3:0] ov[2] = '{default: 4'h0};
  logic [3:0] cl[2] = '{default: 4'h0};
  logic [3:0] sw[2], lv[2], st[2];
  logic fl[2], al[2];
  int fail_count = 0, check_count = 0, cycles = 0;
  chain_spi_if lc();
  chain_spi_if l0();
  chain_spi_if l1();
  assign l0.sclk = lc.sclk;
  assign l0.cs_n = lc.cs_n;
  assign l0.mosi = lc.mosi;
  assign l1.sclk = lc.sclk;
  assign l1.cs_n = lc.cs_n;
  // Released lines show the inverted held value, never a clean stale one
  assign l1.mosi = l0.miso_oe ? l0.miso : ~l0.miso;
  assign lc.miso = l1.miso_oe ? l1.miso : ~l1.miso;
  chain_controller #(.MAX_DEV(4)) i_chain_controller (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .link(lc));
  switch_shift_path i_switch_shift_path_0 (.hclk(hclk), .hresetn(hresetn), .link(l0),
    .overload(ov[0]), .clamping(cl[0]), .switch_on_bits(sw[0]), .serial_error_flag_n(fl[0]),
    .global_alarm_pin_n(al[0]), .live_thermal_fault(lv[0]), .sticky_thermal_fault(st[0]));
  switch_shift_path i_switch_shift_path_1 (.hclk(hclk), .hresetn(hresetn), .link(l1),
    .overload(ov[1]), .clamping(cl[1]), .switch_on_bits(sw[1]), .serial_error_flag_n(fl[1]),
    .global_alarm_pin_n(al[1]), .live_thermal_fault(lv[1]), .sticky_thermal_fault(st[1]));
  chain_spi_asserts i_chain_spi_asserts (.hclk(hclk), .hresetn(hresetn), .sclk(l0.sclk),
    .cs_n(l0.cs_n), .mosi(l0.mosi), .miso(l0.miso), .miso_oe(l0.miso_oe));
  always #5 hclk = ~hclk;
  task automatic results();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Whole run needs a few hundred cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
  endtask
  // Checksum bits left zero: the controller fills them in
  task automatic frame(input logic [7:0] t0, input logic [7:0] t1, input logic [2:0] n);
    bus(1'b1, chain_spi_pkg::OFF_TX0, {24'h0, t0});
    bus(1'b1, chain_spi_pkg::OFF_TX0 + 8'h04, {24'h0, t1});
    bus(1'b1, chain_spi_pkg::OFF_CTRL, {21'h0, n, 8'h01});
    do bus(1'b0, chain_spi_pkg::OFF_STATUS, 32'h0); while (r[0] !== 1'b0);
    repeat (10) @(posedge hclk);
  endtask
  task automatic t_config();
    bus(1'b1, chain_spi_pkg::OFF_IRQ_MASK, 32'h1);
    chk("bus ready", 1'b1, hreadyout);
    chk("bus okay", 1'b0, hresp);
    frame(8'h50, 8'ha0, 3'h2);
    chk("near switches", 4'h5, sw[0]);
    chk("far switches", 4'ha, sw[1]);
    chk("near flag", 1'b1, fl[0]);
    chk("far flag", 1'b1, fl[1]);
    chk("irq raised", 1'b1, irq);
    bus(1'b1, chain_spi_pkg::OFF_IRQ_STAT, 32'h1);
    // The clear lands at the closing edge of the data phase
    @(posedge hclk);
    chk("irq cleared", 1'b0, irq);
  endtask
  task automatic t_diag();
    ov[0] <= 4'h1;
    ov[1] <= 4'hf;
    repeat (10) @(posedge hclk);
    chk("far alarm", 1'b0, al[1]);
    chk("near sticky", 4'h1, st[0]);
    frame(8'h50, 8'ha0, 3'h2);
    bus(1'b0, chain_spi_pkg::OFF_RX0 + 8'h04, 32'h0);
    chk("far diag", 8'haa, r[7:0]);
    bus(1'b0, chain_spi_pkg::OFF_RX0, 32'h0);
    chk("near diag", 8'h11, r[7:0]);
    cl[1] <= 4'hf;
    repeat (10) @(posedge hclk);
    chk("clamp live", 4'h0, lv[1]);
    chk("clamp alarm", 1'b1, al[1]);
  endtask
  // One word only: far device receives the near diagnostics, a bad checksum
  task automatic t_overwrite();
    bus(1'b1, chain_spi_pkg::OFF_IRQ_MASK, 32'h0);
    frame(8'h30, 8'h00, 3'h1);
    chk("near new", 4'h3, sw[0]);
    chk("far held", 4'ha, sw[1]);
    chk("far flag", 1'b0, fl[1]);
    chk("irq masked", 1'b0, irq);
    bus(1'b0, chain_spi_pkg::OFF_IRQ_STAT, 32'h0);
    chk("done sticky", 1'b1, r[0]);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_config();
    t_diag();
    t_overwrite();
    results();
  end
endmodule // daisy_chain_switch_spi_test
